// *** bench/clk_sup_monitor.sv ***
// Checker of the fault lines and the supervisor clock outputs
`timescale 1ns/1ps
`default_nettype none
module clk_sup_monitor (
   input wire logic                   clk_i,
   input wire logic                   rst_i,
   input wire clk_sup_pkg::lines_type noncritical_fault_line,
   input wire logic [1:0]             pll_lock_i,
   input wire logic [1:0]             pll_en_o,
   input wire logic [1:0]             pll_ref_select_o,
   input wire logic                   crystal_osc_en_o,
   input wire logic                   sysclk_sel_pll_o,
   input wire logic                   wb_we_i,
   input wire clk_sup_pkg::adr_type   wb_adr_i,
   input wire logic                   wb_ack_o
);
   import clk_sup_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // A status write acknowledged in the previous cycle
   sequence clr_write;
      $past(wb_ack_o && wb_we_i && (wb_adr_i == 8'h04));
   endsequence
   sequence fail_rise(int b);
      $rose(noncritical_fault_line[b + 2]);
   endsequence
   // Locked or disabled long enough, so any sync lag has drained
   property pll_quiet(int b);
      (pll_lock_i[b] || !pll_en_o[b]) [*6] |=> !noncritical_fault_line[b + 2];
   endproperty
   chk_low_lines: assert property (noncritical_fault_line[1:0] == 2'h0)
      else $error("unused fault lines driven");
   chk_pll0_enabled: assert property (fail_rise(0) |-> $past(pll_en_o[0]))
      else $error("pll0 fail without enable");
   chk_pll1_enabled: assert property (fail_rise(1) |-> $past(pll_en_o[1]))
      else $error("pll1 fail without enable");
   chk_pll0_quiet: assert property (pll_quiet(0))
      else $error("pll0 fail while locked");
   chk_pll1_quiet: assert property (pll_quiet(1))
      else $error("pll1 fail while locked");
   // Checked during reset itself, so the default disable is overridden
   chk_reset_state: assert property (disable iff (1'b0) rst_i |=>
      (noncritical_fault_line == 8'h00) && (pll_en_o == 2'h0) && !crystal_osc_en_o
      && (pll_ref_select_o == 2'h0) && !sysclk_sel_pll_o)
      else $error("outputs not idle after reset");
   chk_flag_hold: assert property (
      |($past(noncritical_fault_line[7:4]) & ~noncritical_fault_line[7:4]) |-> clr_write)
      else $error("monitor line dropped without clear");
   chk_start_quiet: assert property (
      $fell(rst_i) |-> (noncritical_fault_line[7:4] == 4'h0) [*8])
      else $error("monitor fault right after reset");
endmodule
`default_nettype wire

// *** bench/clock_source_supervisor_tb.sv ***
// Self-checking bench of the supervisor and collector pair
`timescale 1ns/1ps
`default_nettype none
module clock_source_supervisor_tb;
   import clk_sup_pkg::*;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   adr_type    adr = 8'h00;
   word_type   wdat = 32'h0;
   word_type   s_rd;
   word_type   c_rd;
   word_type   rd;
   logic       we = 1'b0;
   logic       s_cyc = 1'b0;
   logic       c_cyc = 1'b0;
   logic       s_ack;
   logic       c_ack;
   logic       irq;
   logic       rreq;
   logic       xen;
   logic       ssel;
   logic [1:0] pen;
   logic [1:0] psel;
   logic [1:0] lock = 2'h3;
   logic [4:0] ck = 5'h00;
   logic [4:0] run = 5'h1F;
   int         num_errors = 0;
   int         check_count = 0;
   clk_sup_if fi ();
   always #20 clk_i = ~clk_i;
   // Raw clocks kept well below half the system rate
   // Non-blocking, so a toggle that lands on a clock edge is seen after it
   always #80 if (run[0]) ck[0] <= ~ck[0];
   always #100 if (run[1]) ck[1] <= ~ck[1];
   always #160 if (run[2]) ck[2] <= ~ck[2];
   always #160 if (run[3]) ck[3] <= ~ck[3];
   always #160 if (run[4]) ck[4] <= ~ck[4];
   clock_source_supervisor i_clock_source_supervisor (.clk_i(clk_i), .rst_i(rst_i),
      .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(s_rd), .wb_we_i(we), .wb_sel_i(4'hF),
      .wb_cyc_i(s_cyc), .wb_stb_i(s_cyc), .wb_ack_o(s_ack), .internal_rc_osc_i(ck[0]),
      .crystal_clock_i(ck[1]), .sphere_clk_i(ck[2]), .motor_clk_i(ck[3]),
      .comm_clk_i(ck[4]), .pll_lock_i(lock), .crystal_osc_en_o(xen), .pll_en_o(pen),
      .pll_ref_select_o(psel), .sysclk_sel_pll_o(ssel), .fault_if(fi.device));
   fault_reset_collector i_fault_reset_collector (.clk_i(clk_i), .rst_i(rst_i),
      .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(c_rd), .wb_we_i(we), .wb_sel_i(4'hF),
      .wb_cyc_i(c_cyc), .wb_stb_i(c_cyc), .wb_ack_o(c_ack), .irq_o(irq),
      .reset_req_o(rreq), .fault_if(fi.collector));
   clk_sup_monitor i_clk_sup_monitor (.clk_i(clk_i), .rst_i(rst_i),
      .noncritical_fault_line(fi.noncritical_fault_line), .pll_lock_i(lock),
      .pll_en_o(pen), .pll_ref_select_o(psel), .crystal_osc_en_o(xen),
      .sysclk_sel_pll_o(ssel), .wb_we_i(we), .wb_adr_i(adr), .wb_ack_o(s_ack));
   task automatic summarize();
      $display("Checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input word_type g, input word_type e, input string msg);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %0t %s got %h exp %h", $time, msg, g, e);
      end
   endtask
   // One classic cycle; m picks the collector, else the supervisor
   task automatic bus(input bit m, input adr_type a, input logic w, input word_type d);
      int n;
      n = 0;
      adr <= a;
      we <= w;
      wdat <= d;
      if (m) c_cyc <= 1'b1;
      else s_cyc <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while ((m ? c_ack : s_ack) !== 1'b1 && n < 50);
      rd = m ? c_rd : s_rd;
      c_cyc <= 1'b0;
      s_cyc <= 1'b0;
      @(posedge clk_i);
      if (n >= 50) chk(32'h0, 32'h1, "bus timeout");
      if (n >= 50) summarize();
   endtask
   task automatic rdc(input bit m, input adr_type a, input word_type e);
      bus(m, a, 1'b0, 32'h0);
      chk(rd, e, "read");
   endtask
   task automatic wait_line(input int b, input logic v, input int lim);
      int n;
      n = 0;
      while (fi.noncritical_fault_line[b] !== v && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      chk(word_type'(fi.noncritical_fault_line[b]), word_type'(v), "fault line");
      if (n >= lim) summarize();
   endtask
   task automatic t_reset();
      chk(word_type'({xen, pen, psel, ssel}), 32'h0, "outputs");
      rdc(0, 8'h00, 32'h0);
      rdc(0, 8'h04, 32'h0);
      rdc(0, 8'h10, 32'h0000FFFF);
      rdc(0, 8'h14, 32'h0);
      rdc(0, 8'h40, 32'h0);
      rdc(1, 8'h0C, 32'h0);
      $display("t_reset done");
   endtask
   task automatic t_pll();
      bus(0, 8'h00, 1, 32'h1F0);
      chk(word_type'({xen, pen, psel}), 32'h1F, "enables");
      bus(0, 8'h00, 1, 32'h9F0);
      repeat (8) @(posedge clk_i);
      chk(word_type'(ssel), 32'h1, "pll selected");
      rdc(0, 8'h04, 32'h00040000);
      bus(1, 8'h08, 1, 32'h0C);
      bus(1, 8'h0C, 1, 32'h04);
      lock <= 2'h0;
      wait_line(2, 1, 20);
      wait_line(3, 1, 20);
      rdc(0, 8'h04, 32'h0);
      chk(word_type'(rreq), 32'h1, "reset request");
      bus(0, 8'h00, 1, 32'hBF0);
      wait_line(2, 0, 20);
      repeat (2) @(posedge clk_i);
      chk(word_type'(rreq), 32'h0, "request with alt off");
      lock <= 2'h3;
      wait_line(3, 0, 20);
      bus(0, 8'h00, 1, 32'h1F0);
      $display("t_pll done");
   endtask
   task automatic t_mon();
      for (int i = 0; i < 3; i++) begin
         bus(0, 8'(8'h10 + 8 * i), 1, 32'h28);
         bus(0, 8'(8'h14 + 8 * i), 1, 32'h14);
      end
      bus(0, 8'h00, 1, 32'h1F1);
      repeat (600) @(posedge clk_i);
      chk(word_type'(fi.noncritical_fault_line[7:4]), 32'h0, "in range");
      run[3] = 1'b0;
      wait_line(6, 1, 700);
      run[3] = 1'b1;
      repeat (600) @(posedge clk_i);
      chk(word_type'(fi.noncritical_fault_line[6]), 32'h1, "held");
      rdc(0, 8'h04, 32'h400);
      bus(0, 8'h04, 1, 32'h400);
      wait_line(6, 0, 5);
      bus(0, 8'h20, 1, 32'h10);
      wait_line(7, 1, 700);
      bus(0, 8'h20, 1, 32'h28);
      repeat (600) @(posedge clk_i);
      bus(0, 8'h04, 1, 32'h800);
      wait_line(7, 0, 5);
      bus(0, 8'h00, 1, 32'h1F5);
      run[1] = 1'b0;
      // Divider 2 gives 256-cycle windows; an undivided one would flag by now
      repeat (150) @(posedge clk_i);
      chk(word_type'(fi.noncritical_fault_line[4]), 32'h0, "divided window");
      wait_line(4, 1, 700);
      run[1] = 1'b1;
      repeat (100) @(posedge clk_i);
      bus(0, 8'h04, 1, 32'h100);
      wait_line(4, 0, 5);
      chk(word_type'(irq), 32'h0, "irq masked");
      bus(1, 8'h04, 1, 32'h40);
      repeat (2) @(posedge clk_i);
      chk(word_type'(irq), 32'h1, "irq raised");
      rdc(1, 8'h00, 32'hDC);
      rdc(1, 8'h00, 32'h0);
      chk(word_type'(irq), 32'h0, "irq cleared");
      $display("t_mon done");
   endtask
   task automatic t_meter();
      int n;
      n = 0;
      bus(0, 8'h00, 1, 32'h1F9);
      rdc(0, 8'h04, 32'h1);
      do begin
         bus(0, 8'h04, 0, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 2000);
      chk(word_type'(n < 2000), 32'h1, "meter done");
      bus(0, 8'h08, 0, 32'h0);
      chk(word_type'(rd >= 32'h332 && rd <= 32'h334), 32'h1, "meter count");
      run[0] = 1'b0;
      wait_line(5, 1, 60);
      bus(0, 8'h00, 1, 32'h1F9);
      repeat (6000) @(posedge clk_i);
      bus(0, 8'h04, 0, 32'h0);
      chk(word_type'(rd[0]), 32'h1, "meter stuck");
      $display("t_meter done");
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_pll();
      t_mon();
      t_meter();
      summarize();
   end
endmodule
`default_nettype wire

// *** common/clk_sup_cfg.svh ***
// Offsets, field positions, reset values and counts of the clock supervisor pair
// Contract
// [RQ1] Meter times RC oscillator against crystal clock
// [RQ2] Software checks RC near 16 MHz, 6 %
// [RQ3] Dead RC oscillator leaves meter running forever
// [RQ4] Software waits meter flag zero, with timeout
// [RQ5] PLL loss of lock drives lines 2, 3
// [RQ6] PLL fail passes unmasked; reset needs enables; code lets control bits 9, 10 mask PLL fail
// [RQ7] After reset crystal off, PLLs off, RC clock
// [RQ8] Reference select 1 picks crystal for PLL
// [RQ9] Clock status reads 4 when PLL drives
// [RQ10] Monitors use RC reference, catch losses, range
// [RQ11] Monitor zero: sphere line 5, crystal 4
// [RQ12] Monitor one: motor clock, line 6
// [RQ13] Monitor two: protocol clock, line 7
// [RQ14] Divided RC window checks crystal for loss
// [RQ15] Count above high or below low faults
// [RQ16] Monitoring starts only once enable bit set
// [RQ17] Software repeats RC check every fault interval
// [RQ18] Monitor flags hold until software clears them
`ifndef CLK_SUP_CFG_SVH
`define CLK_SUP_CFG_SVH

// Supervisor register offsets
`define SUP_CTRL_OFS     8'h00
`define SUP_STATUS_OFS   8'h04
`define SUP_METER_OFS    8'h08
`define SUP_LIMIT_OFS    8'h10
`define SUP_CTRL_RST     32'h0000_0000
`define SUP_HI_RST       16'hFFFF
`define SUP_LO_RST       16'h0000

// Control fields
`define CTRL_MON_EN      0
`define CTRL_DIV_LSB     1
`define CTRL_METER_GO    3
`define CTRL_XTAL_EN     4
`define CTRL_PLL_EN_LSB  5
`define CTRL_REFSEL_LSB  7
`define CTRL_MASK_LSB    9
`define CTRL_SYSCLK_PLL  11

// Status fields
`define STAT_METER_RUN   0
`define STAT_FLAG_LSB    8
`define STAT_SYSCLK_LSB  16
`define SYSCLK_RC        3'h0
`define SYSCLK_PLL       3'h4

// Fault line positions
`define LINE_PLL0        2
`define LINE_XTAL        4
`define LINE_SPHERE      5

// Collector register offsets
`define COL_STATUS_OFS   8'h00
`define COL_MASK_OFS     8'h04
`define COL_DELAY_OFS    8'h08
`define COL_ALT_OFS      8'h0C
`define COL_REG_RST      8'h00

// Timing counts
`define MON_WINDOW       8'd64
`define METER_WINDOW     16'd1024
`define XTAL_BASE        8'd16
`define CLK_PERIOD_NS    40
`define REF_LOSS_NS      1000
`define REF_LOSS_CYC     8'(`REF_LOSS_NS / `CLK_PERIOD_NS)

`endif

// *** common/clk_sup_if.sv ***
// Fault line carrier between the clock supervisor and the fault collector
`timescale 1ns/1ps
`default_nettype none
interface clk_sup_if;
   import clk_sup_pkg::*;
   lines_type noncritical_fault_line;
   modport device (output noncritical_fault_line);
   modport collector (input noncritical_fault_line);
endinterface
`default_nettype wire

// *** common/clk_sup_pkg.sv ***
// Types and shared helpers of the clock supervisor pair
package clk_sup_pkg;
   typedef logic [7:0]  adr_type;
   typedef logic [31:0] word_type;
   typedef logic [3:0]  sel_type;
   typedef logic [7:0]  lines_type;
   typedef enum logic {METER_IDLE, METER_RUN} meter_state_type;

   // Byte-lane merge of a Wishbone write
   function automatic word_type merge_bytes(input word_type old_v, input word_type new_v,
                                            input sel_type sel);
      word_type r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction
endpackage

// *** rtl/clock_source_supervisor.sv ***
// Clock source supervisor: RC meter, clock monitors, PLL fail lines, source control
`timescale 1ns/1ps
`default_nettype none
`include "clk_sup_cfg.svh"
module clock_source_supervisor (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire clk_sup_pkg::adr_type  wb_adr_i,
   input  wire clk_sup_pkg::word_type wb_dat_i,
   output var  clk_sup_pkg::word_type wb_dat_o,
   input  wire logic                  wb_we_i,
   input  wire clk_sup_pkg::sel_type  wb_sel_i,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   output var  logic                  wb_ack_o,
   input  wire logic                  internal_rc_osc_i,
   input  wire logic                  crystal_clock_i,
   input  wire logic                  sphere_clk_i,
   input  wire logic                  motor_clk_i,
   input  wire logic                  comm_clk_i,
   input  wire logic [1:0]            pll_lock_i,
   output var  logic                  crystal_osc_en_o,
   output var  logic [1:0]            pll_en_o,
   output var  logic [1:0]            pll_ref_select_o,
   output var  logic                  sysclk_sel_pll_o,
   clk_sup_if.device                  fault_if
);
   import clk_sup_pkg::*;

   // Sampled clocks: 0 RC, 1 crystal, 2 sphere, 3 motor, 4 protocol, 5..6 locks.
   // Monitored clocks must stay below half of clk_i to be counted faithfully.
   logic [6:0]      sync1;
   logic [6:0]      sync2;
   logic [4:0]      prev;
   logic [4:0]      rise;
   word_type        ctrl;
   word_type        wctrl;
   logic [15:0]     hi_lim [3];
   logic [15:0]     lo_lim [3];
   logic [15:0]     mon_cnt [3];
   logic [7:0]      win_cnt;
   logic [7:0]      xtal_cnt;
   logic            xtal_seen;
   logic [7:0]      idle_cnt;
   logic [3:0]      flag;
   logic [3:0]      flag_set;
   logic [3:0]      flag_clr;
   logic [1:0]      pll_fail;
   logic [2:0]      sysclk_status;
   meter_state_type meter_state;
   logic [15:0]     meter_ref;
   logic [15:0]     meter_count;
   logic            access;
   logic            wr;
   logic            mon_en;
   logic            win_end;
   logic            xtal_end;

   function automatic logic [7:0] xtal_period(input logic [1:0] div_sel);
      return 8'(`XTAL_BASE << div_sel);
   endfunction

   assign access   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr       = access & wb_we_i;
   assign wctrl    = merge_bytes(ctrl, wb_dat_i, wb_sel_i);
   assign mon_en   = ctrl[`CTRL_MON_EN];
   assign rise     = sync2[4:0] & ~prev;
   assign win_end  = rise[0] && (win_cnt == `MON_WINDOW - 8'd1);
   assign xtal_end = rise[0] && (xtal_cnt == xtal_period(ctrl[`CTRL_DIV_LSB +: 2]) - 8'd1);

   // Two stages before any logic looks at a foreign clock or lock level
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1 <= 7'h00;
         sync2 <= 7'h00;
         prev  <= 5'h00;
      end else begin
         sync1 <= {pll_lock_i, comm_clk_i, motor_clk_i, sphere_clk_i,
                   crystal_clock_i, internal_rc_osc_i};
         sync2 <= sync1;
         prev  <= sync2[4:0];
      end
   end

   // Bus slave: one wait state, unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= access;
         if (access && !wb_we_i) begin
            wb_dat_o <= 32'h0000_0000;
            case (wb_adr_i)
               `SUP_CTRL_OFS:   wb_dat_o <= ctrl;
               `SUP_STATUS_OFS: wb_dat_o <= {13'h0000, sysclk_status, 4'h0, flag, 7'h00,
                                             meter_state == METER_RUN}; // [RQ4]
               `SUP_METER_OFS:  wb_dat_o <= {16'h0000, meter_count};
               default: begin
                  for (int i = 0; i < 3; i++) begin
                     if (wb_adr_i == `SUP_LIMIT_OFS + 8'(i * 8)) begin
                        wb_dat_o <= {16'h0000, hi_lim[i]};
                     end
                     if (wb_adr_i == `SUP_LIMIT_OFS + 8'(i * 8 + 4)) begin
                        wb_dat_o <= {16'h0000, lo_lim[i]};
                     end
                  end
               end
            endcase
         end
      end
   end

   // Reset leaves crystal off, PLLs off and the RC clock in charge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= `SUP_CTRL_RST; // [RQ7]
      end else if (wr && wb_adr_i == `SUP_CTRL_OFS) begin
         ctrl <= wctrl & ~(32'h1 << `CTRL_METER_GO);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 3; i++) begin
            hi_lim[i] <= `SUP_HI_RST;
            lo_lim[i] <= `SUP_LO_RST;
         end
      end else if (wr) begin
         for (int i = 0; i < 3; i++) begin
            if (wb_adr_i == `SUP_LIMIT_OFS + 8'(i * 8)) begin
               hi_lim[i] <= wb_dat_i[15:0];
            end
            if (wb_adr_i == `SUP_LIMIT_OFS + 8'(i * 8 + 4)) begin
               lo_lim[i] <= wb_dat_i[15:0];
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         crystal_osc_en_o <= 1'b0;
         pll_en_o         <= 2'b00;
         pll_ref_select_o <= 2'b00;
         sysclk_sel_pll_o <= 1'b0;
      end else begin
         crystal_osc_en_o <= ctrl[`CTRL_XTAL_EN];
         pll_en_o         <= ctrl[`CTRL_PLL_EN_LSB +: 2];
         pll_ref_select_o <= ctrl[`CTRL_REFSEL_LSB +: 2]; // [RQ8]
         sysclk_sel_pll_o <= ctrl[`CTRL_SYSCLK_PLL];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sysclk_status <= `SYSCLK_RC;
      end else if (ctrl[`CTRL_SYSCLK_PLL] && pll_en_o[0] && sync2[5]) begin
         sysclk_status <= `SYSCLK_PLL; // [RQ9]
      end else begin
         sysclk_status <= `SYSCLK_RC;
      end
   end

   // Meter window is counted in RC edges, so a dead RC never finishes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meter_state <= METER_IDLE;
         meter_ref   <= 16'h0000;
         meter_count <= 16'h0000;
      end else begin
         case (meter_state)
            METER_IDLE: begin
               if (wr && wb_adr_i == `SUP_CTRL_OFS && wctrl[`CTRL_METER_GO]) begin
                  meter_state <= METER_RUN;
                  meter_ref   <= 16'h0000;
                  meter_count <= 16'h0000;
               end
            end
            METER_RUN: begin
               if (rise[1]) begin
                  meter_count <= meter_count + 16'h0001; // [RQ1]
               end
               if (rise[0]) begin
                  meter_ref <= meter_ref + 16'h0001;
                  if (meter_ref == `METER_WINDOW - 16'd1) begin
                     meter_state <= METER_IDLE; // [RQ3]
                  end
               end
            end
            default: meter_state <= METER_IDLE;
         endcase
      end
   end

   // Range windows of RC edges; idle until enabled
   always_ff @(posedge clk_i) begin
      if (rst_i || !mon_en) begin
         win_cnt <= 8'h00;
         for (int i = 0; i < 3; i++) begin
            mon_cnt[i] <= 16'h0000;
         end
      end else begin
         if (rise[0]) begin
            win_cnt <= win_end ? 8'h00 : win_cnt + 8'h01; // [RQ10]
         end
         for (int i = 0; i < 3; i++) begin
            if (win_end) begin
               mon_cnt[i] <= 16'h0000;
            end else if (rise[i + 2]) begin
               mon_cnt[i] <= mon_cnt[i] + 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !mon_en) begin
         xtal_cnt  <= 8'h00;
         xtal_seen <= 1'b0;
         idle_cnt  <= 8'h00;
      end else begin
         if (rise[0]) begin
            xtal_cnt <= xtal_end ? 8'h00 : xtal_cnt + 8'h01; // [RQ14]
         end
         xtal_seen <= xtal_end ? rise[1] : (xtal_seen | rise[1]);
         idle_cnt  <= rise[0] ? 8'h00 : (idle_cnt == `REF_LOSS_CYC ? idle_cnt
                                         : idle_cnt + 8'h01);
      end
   end

   // Flag order: crystal, sphere (and lost reference), motor, protocol
   always_comb begin
      flag_set = 4'h0;
      if (mon_en) begin // [RQ16]
         flag_set[0] = xtal_end && !xtal_seen && !rise[1];
         flag_set[1] = idle_cnt == `REF_LOSS_CYC;
         for (int i = 0; i < 3; i++) begin
            if (win_end && (mon_cnt[i] > hi_lim[i] || mon_cnt[i] < lo_lim[i])) begin
               flag_set[i + 1] = 1'b1; // [RQ15]
            end
         end
      end
      flag_clr = 4'h0;
      if (wr && wb_adr_i == `SUP_STATUS_OFS && wb_sel_i[1]) begin
         flag_clr = wb_dat_i[`STAT_FLAG_LSB +: 4];
      end
   end

   // Write one to clear; a fault in the same cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag <= 4'h0;
      end else begin
         flag <= (flag & ~flag_clr) | flag_set; // [RQ18]
      end
   end

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         pll_fail[i] = pll_en_o[i] & ~sync2[i + 5] & ~ctrl[`CTRL_MASK_LSB + i]; // [RQ6]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fault_if.noncritical_fault_line <= 8'h00;
      end else begin
         fault_if.noncritical_fault_line <= {flag, pll_fail, 2'b00}; // [RQ5] [RQ11] [RQ12] [RQ13]
      end
   end
endmodule
`default_nettype wire

// *** rtl/fault_reset_collector.sv ***
// Fault collector and reset generator end fed by the supervisor fault lines
`timescale 1ns/1ps
`default_nettype none
`include "clk_sup_cfg.svh"
module fault_reset_collector (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire clk_sup_pkg::adr_type  wb_adr_i,
   input  wire clk_sup_pkg::word_type wb_dat_i,
   output var  clk_sup_pkg::word_type wb_dat_o,
   input  wire logic                  wb_we_i,
   input  wire clk_sup_pkg::sel_type  wb_sel_i,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   output var  logic                  wb_ack_o,
   output var  logic                  irq_o,
   output var  logic                  reset_req_o,
   clk_sup_if.collector               fault_if
);
   import clk_sup_pkg::*;

   lines_type status;
   lines_type mask;
   lines_type delay_cfg;
   lines_type alt_cfg;
   logic      access;
   logic      rd_status;
   word_type  wmask;
   word_type  wdelay;
   word_type  walt;

   assign access    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign rd_status = access & ~wb_we_i & (wb_adr_i == `COL_STATUS_OFS);
   assign wmask     = merge_bytes({24'h000000, mask}, wb_dat_i, wb_sel_i);
   assign wdelay    = merge_bytes({24'h000000, delay_cfg}, wb_dat_i, wb_sel_i);
   assign walt      = merge_bytes({24'h000000, alt_cfg}, wb_dat_i, wb_sel_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= access;
         if (access && !wb_we_i) begin
            case (wb_adr_i)
               `COL_STATUS_OFS: wb_dat_o <= {24'h000000, status};
               `COL_MASK_OFS:   wb_dat_o <= {24'h000000, mask};
               `COL_DELAY_OFS:  wb_dat_o <= {24'h000000, delay_cfg};
               `COL_ALT_OFS:    wb_dat_o <= {24'h000000, alt_cfg};
               default:         wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask      <= `COL_REG_RST;
         delay_cfg <= `COL_REG_RST;
         alt_cfg   <= `COL_REG_RST;
      end else if (access && wb_we_i) begin
         case (wb_adr_i)
            `COL_MASK_OFS:  mask <= wmask[7:0];
            `COL_DELAY_OFS: delay_cfg <= wdelay[7:0];
            `COL_ALT_OFS:   alt_cfg <= walt[7:0];
            default:        mask <= mask;
         endcase
      end
   end

   // Sticky capture; a line active during the clearing read survives it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status <= `COL_REG_RST;
      end else begin
         status <= (rd_status ? 8'h00 : status) | fault_if.noncritical_fault_line;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o       <= 1'b0;
         reset_req_o <= 1'b0;
      end else begin
         irq_o       <= |(status & mask);
         // Reset only for lines software has armed in both enable registers
         reset_req_o <= |(fault_if.noncritical_fault_line & delay_cfg & alt_cfg); // [RQ6]
      end
   end
endmodule
`default_nettype wire
